// *** bench/rtcsl_host_model.sv ***
// Host model that writes and reads the control registers of the clock block.
`timescale 1ns/100ps
module rtcsl_host_model import rtcsl_pkg::*; (
	input wire logic sys_clk,
	output logic reg_wr_en,
	output rtcsl_reg_wr_t reg_wr,
	output logic [3:0] reg_rd_addr,
	input wire logic [7:0] reg_rd_data
);
	initial begin
		reg_wr_en = 1'h0;
		reg_wr = '0;
		reg_rd_addr = 4'h0;
	end
	// Idle data is inverted after each write so a stale value never looks valid.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		reg_wr_en = 1'h1;
		reg_wr.addr = a;
		reg_wr.data = (a == RTCSL_ADDR_CTRL1) ? (d & 8'hF7) : d;
		@(posedge sys_clk) #1;
		reg_wr_en = 1'h0;
		reg_wr.data = ~reg_wr.data;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		reg_rd_addr = a;
		@(posedge sys_clk) #1;
		d = reg_rd_data;
	endtask
endmodule

// *** bench/tb.sv ***
// Self-checking testbench of the control and status block.
`timescale 1ns/100ps
module tb import rtcsl_pkg::*;;
	localparam int ADLY = 8;
	typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} rtcsl_row_t;
	logic sys_clk, rst, osc_32k, supply_below, osc_halt, am_w, am_d, h24, tmode, vsel, mon_en, irq_n, reg_wr_en;
	logic [5:0] hour_in, hour_out;
	logic [7:0] rdat, v, adj_o;
	logic [3:0] rd_addr;
	rtcsl_reg_wr_t reg_wr;
	int n_errors, n_checks, n;
	rtcsl_row_t rows[10] = '{'{4'hE, 8'h30, 8'h30}, '{4'hE, 8'h04, 8'h04}, '{4'hE, 8'h05, 8'h05},
		'{4'hE, 8'h06, 8'h06}, '{4'hE, 8'h07, 8'h07}, '{4'hE, 8'h00, 8'h00}, '{4'hF, 8'h88, 8'h88},
		'{4'hF, 8'h7F, 8'h28}, '{4'h7, 8'h5A, 8'h5A}, '{4'hD, 8'h55, 8'h00}};
	logic [5:0] hin[7] = '{6'h00, 6'h01, 6'h11, 6'h12, 6'h13, 6'h23, 6'h09};
	logic [5:0] hexp[7] = '{6'h12, 6'h01, 6'h11, 6'h32, 6'h21, 6'h31, 6'h09};

	rtcsl_host_model u_host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_wr(reg_wr), .reg_rd_addr(rd_addr),
		.reg_rd_data(rdat));
	rtcsl_ctrl #(.SEC_DELAY_CYC(10), .ALARM_DELAY_CYC(ADLY)) u_dut (.sys_clk(sys_clk), .rst(rst), .osc_32k(osc_32k),
		.supply_below(supply_below), .osc_halt(osc_halt), .reg_wr_en(reg_wr_en), .reg_wr(reg_wr),
		.reg_rd_addr(rd_addr), .reg_rd_data(rdat), .carry('0), .hour_in_bcd(hour_in), .hour_out(hour_out),
		.alarm_w_match(am_w), .alarm_d_match(am_d), .adj_due(1'h0), .adj_slow(1'h0), .adj_ticks(7'h00),
		.osc_adj(adj_o), .sec_tick(), .hour_24_mode(h24), .test_mode(tmode), .supply_threshold_select(vsel),
		.monitor_enable(mon_en), .irq_out_n(irq_n));

	// ==========
	// Helpers
	// ==========
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		u_host.rd(a, v);
		chk(what, v, exp);
	endtask
	task automatic wait_irq(input logic lv, input int lim);
		n = 0;
		while (irq_n !== lv) begin
			@(posedge sys_clk) #1;
			n++;
			if (n > lim) begin
				n_errors++;
				wrap_up();
			end
		end
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		osc_32k = 1'h0;
		forever #20 osc_32k = ~osc_32k;
	end

	// ==========
	// Main sequence
	// ==========
	initial begin
		{rst, supply_below, osc_halt, am_w, am_d} = 5'h10;
		hour_in = 6'h00;
		repeat (20) @(posedge sys_clk);
		#1 rst = 1'h0;
		chk("irq", {7'h0, irq_n}, 8'h01);
		chk("test", {7'h0, tmode}, 8'h00);
		rdchk("ctrl2", 4'hF, 8'h10);
		u_host.wr(4'hE, 8'h10);
		u_host.wr(4'h7, 8'h33);
		rdchk("ctrl1", 4'hE, 8'h00);
		rdchk("adj", 4'h7, 8'h00);
		u_host.wr(4'hF, 8'hFF);
		rdchk("ctrl2", 4'hF, 8'h30);
		u_host.wr(4'hF, 8'h08);
		rdchk("ctrl2", 4'hF, 8'h08);
		foreach (rows[i]) begin
			u_host.wr(rows[i].a, rows[i].d);
			rdchk("row", rows[i].a, rows[i].e);
		end
		chk("vsel", {7'h0, vsel}, 8'h00);
		chk("osc_adj", adj_o, 8'h5A);
		foreach (hin[i]) begin
			hour_in = hin[i];
			repeat (2) @(posedge sys_clk) #1;
			chk("hour12", {2'h0, hour_out}, {2'h0, hexp[i]});
		end
		u_host.wr(4'hE, 8'h20);
		repeat (2) @(posedge sys_clk) #1;
		chk("hour24", {h24, 1'h0, hour_out}, 8'h89);
		u_host.wr(4'hE, 8'h01);
		repeat (3) @(posedge sys_clk) #1;
		chk("irq low", {7'h0, irq_n}, 8'h00);
		u_host.rd(4'hF, v);
		chk("pflag", {7'h0, v[2]}, 8'h01);
		u_host.wr(4'hE, 8'h00);
		wait_irq(1'h1, 5);
		for (int k = 0; k < 2; k++) begin
			for (int en = 0; en < 2; en++) begin
				u_host.wr(4'hE, en ? (k ? 8'h80 : 8'h40) : 8'h00);
				@(posedge sys_clk) #1;
				{am_w, am_d} = k ? 2'h2 : 2'h1;
				@(posedge sys_clk) #1;
				{am_w, am_d} = 2'h0;
				if (en) begin
					wait_irq(1'h0, ADLY + 6);
					chk("alarm dly", {7'h0, n >= ADLY - 2}, 8'h01);
				end else begin
					repeat (ADLY + 6) @(posedge sys_clk) #1;
					chk("irq off", {7'h0, irq_n}, 8'h01);
				end
				u_host.rd(4'hF, v);
				chk("aflag", {6'h0, v[1:0]}, en ? (k ? 8'h02 : 8'h01) : 8'h00);
			end
			u_host.wr(4'hF, 8'h00);
			wait_irq(1'h1, 4);
			rdchk("aclr", 4'hF, 8'h00);
		end
		supply_below = 1'h1;
		repeat (6) @(posedge sys_clk) #1;
		supply_below = 1'h0;
		repeat (6) @(posedge sys_clk) #1;
		chk("mon", {7'h0, mon_en}, 8'h00);
		rdchk("vlow", 4'hF, 8'h40);
		u_host.wr(4'hF, 8'h20);
		rdchk("vclr", 4'hF, 8'h20);
		chk("mon", {7'h0, mon_en}, 8'h01);
		osc_halt = 1'h1;
		repeat (6) @(posedge sys_clk) #1;
		u_host.wr(4'hF, 8'h20);
		rdchk("halt", 4'hF, 8'h00);
		osc_halt = 1'h0;
		repeat (6) @(posedge sys_clk) #1;
		rdchk("halt", 4'hF, 8'h00);
		u_host.wr(4'hE, 8'h02);
		u_host.wr(4'h0, 8'h00);
		repeat (2) @(posedge sys_clk) #1;
		chk("sec wr", {7'h0, irq_n}, 8'h00);
		u_host.rd(4'hF, v);
		chk("pflag", {7'h0, v[2]}, 8'h01);
		wait_irq(1'h1, 40000);
		chk("2hz low", {7'h0, n > 32700 && n < 32800}, 8'h01);
		rst = 1'h1;
		repeat (3) @(posedge sys_clk);
		#1 rst = 1'h0;
		chk("irq", {7'h0, irq_n}, 8'h01);
		chk("osc_adj", adj_o, 8'h00);
		rdchk("ctrl2", 4'hF, 8'h10);
		wrap_up();
	end
endmodule

// *** core/rtcsl_ctrl.sv ***
// Control and status registers, periodic and alarm interrupt logic of the clock.
// Operation
// - Each alarm enable bit turns its alarm interrupt on at 1, off at 0.
// - Hour format bit: 0 gives 12-hour with AM/PM, 1 gives 24-hour.
// - 12-hour coding: AM 12,01-11; PM 32,21-31; bit 5 marks PM.
// - First scratch bit stores writes and is zero while power-on flag is set.
// - Select 000 keeps the interrupt high; 001 holds it low.
// - Pulse codes 010 and 011 give 2 Hz and 1 Hz square waves.
// - Level codes flag each second, minute, hour or month start.
// - In pulse mode seconds advance about 92 us after the falling edge.
// - Writing the second counter clears the sub-second divider and, with pulse codes 010/011, drives output low.
// - In level mode the interrupt falls together with the second increment.
// - Oscillation adjustment shifts the periodic timing by up to 3.784 ms.
// - Threshold select: 0 picks the higher supply threshold, 1 the lower.
// - Supply-low flag sets below threshold, then holds and stops monitoring.
// - Writing 0 clears the supply-low flag and restarts monitoring; 1 does nothing.
// - Oscillation-halt flag is read/write, forced 0 on halt, stays 0 after.
// - Power-on flag sets on power-up from zero and keeps its value.
// - While power-on flag is set all other control bits except halt flag are zero.
// - Power-on flag clears only by writing 0; writing 1 does nothing.
// - Second scratch bit stores writes and is zero while power-on flag is set.
// - Periodic flag reads 1 while output is low; level mode write 0 releases it.
// - Alarm flags set about 61 us after a match, clear by 0, read 0 if disabled.
`timescale 1ns/100ps
module rtcsl_ctrl import rtcsl_pkg::*; #(
	parameter int SEC_DELAY_CYC = RTCSL_SEC_DELAY_CYC,
	parameter int ALARM_DELAY_CYC = RTCSL_ALARM_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic osc_32k,
	input wire logic supply_below,
	input wire logic osc_halt,
	input wire logic reg_wr_en,
	input wire rtcsl_reg_wr_t reg_wr,
	input wire logic [3:0] reg_rd_addr,
	output logic [7:0] reg_rd_data,
	input wire rtcsl_carry_t carry,
	input wire logic [5:0] hour_in_bcd,
	output logic [5:0] hour_out,
	input wire logic alarm_w_match,
	input wire logic alarm_d_match,
	input wire logic adj_due,
	input wire logic adj_slow,
	input wire logic [6:0] adj_ticks,
	output logic [7:0] osc_adj,
	output logic sec_tick,
	output logic hour_24_mode,
	output logic test_mode,
	output logic supply_threshold_select,
	output logic monitor_enable,
	output logic irq_out_n
);
	// ==========================================================================
	// Pin synchronisers and divider
	// ==========================================================================
	logic osc_lvl, supply_lvl, halt_lvl;
	logic osc_prev_ff, nxt_osc_prev, tick_32k;
	logic wave_1hz_low, wave_2hz_low;

	rtcsl_sync3 u_sync_osc (.sys_clk(sys_clk), .rst(rst), .pin_in(osc_32k), .level_out(osc_lvl));
	rtcsl_sync3 u_sync_vdd (.sys_clk(sys_clk), .rst(rst), .pin_in(supply_below), .level_out(supply_lvl));
	rtcsl_sync3 u_sync_halt (.sys_clk(sys_clk), .rst(rst), .pin_in(osc_halt), .level_out(halt_lvl));

	always_comb begin
		nxt_osc_prev = osc_lvl;
	end

	assign tick_32k = osc_lvl & ~osc_prev_ff;

	logic sec_write;
	assign sec_write = reg_wr_en && reg_wr.addr == RTCSL_ADDR_SEC;

	rtcsl_periodic #(.SEC_DELAY_CYC(SEC_DELAY_CYC)) u_periodic (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick_32k(tick_32k),
		.sec_write(sec_write),
		.adj_due(adj_due),
		.adj_slow(adj_slow),
		.adj_ticks(adj_ticks),
		.wave_1hz_low(wave_1hz_low),
		.wave_2hz_low(wave_2hz_low),
		.sec_tick(sec_tick)
	);

	// ==========================================================================
	// Registers
	// ==========================================================================
	logic [7:0] ctrl1_ff, nxt_ctrl1, adj_ff, nxt_adj;
	logic vsel_ff, vlow_ff, xst_ff, pon_ff, spare_a_ff, lvl_ff, weekly_alarm_flag_ff, daily_alarm_flag_ff;
	logic nxt_vsel, nxt_vlow, nxt_xst, nxt_pon, nxt_spare_a, nxt_lvl, nxt_weekly_alarm_flag, nxt_daily_alarm_flag;
	logic [RTCSL_DLY_W-1:0] al_dly_ff [2];
	logic [RTCSL_DLY_W-1:0] nxt_al_dly [2];
	logic [1:0] al_run_ff, nxt_al_run, al_hit;
	logic [7:0] rd_ff, nxt_rd;
	logic [5:0] hour_ff, nxt_hour;
	logic irq_n_ff, nxt_irq_n;
	logic wr1, wr2, wr_adj, level_mode, level_event, per_low;
	rtcsl_psel_t psel;

	assign wr1 = reg_wr_en && reg_wr.addr == RTCSL_ADDR_CTRL1;
	assign wr2 = reg_wr_en && reg_wr.addr == RTCSL_ADDR_CTRL2;
	assign wr_adj = reg_wr_en && reg_wr.addr == RTCSL_ADDR_OSC_ADJ;
	assign psel = rtcsl_psel_t'(ctrl1_ff[RTCSL_C1_SEL_LSB +: 3]);
	assign level_mode = ctrl1_ff[RTCSL_C1_SEL_LSB + 2];

	always_comb begin
		unique case (psel)
			RTCSL_PS_LSEC: level_event = sec_tick;
			RTCSL_PS_LMIN: level_event = sec_tick & carry.minute;
			RTCSL_PS_LHOUR: level_event = sec_tick & carry.hour;
			RTCSL_PS_LMONTH: level_event = sec_tick & carry.month;
			default: level_event = 1'b0;
		endcase
		unique case (psel)
			RTCSL_PS_OFF: per_low = 1'b0;
			RTCSL_PS_LOW: per_low = 1'b1;
			RTCSL_PS_P2HZ: per_low = wave_2hz_low;
			RTCSL_PS_P1HZ: per_low = wave_1hz_low;
			default: per_low = lvl_ff;
		endcase
	end

	always_comb begin
		nxt_pon = pon_ff;
		if (wr2 && !reg_wr.data[RTCSL_C2_PON])
			nxt_pon = 1'b0;
		nxt_ctrl1 = wr1 ? reg_wr.data : ctrl1_ff;
		nxt_adj = wr_adj ? reg_wr.data : adj_ff;
		nxt_vsel = wr2 ? reg_wr.data[RTCSL_C2_VSEL] : vsel_ff;
		nxt_spare_a = wr2 ? reg_wr.data[RTCSL_C2_SPARE_A] : spare_a_ff;
		nxt_xst = wr2 ? reg_wr.data[RTCSL_C2_XST] : xst_ff;
		if (halt_lvl)
			nxt_xst = 1'b0;
		nxt_vlow = vlow_ff;
		if (vlow_ff && wr2 && !reg_wr.data[RTCSL_C2_VLOW])
			nxt_vlow = 1'b0;
		else if (!vlow_ff && supply_lvl)
			nxt_vlow = 1'b1;
		nxt_lvl = lvl_ff;
		if (wr2 && !reg_wr.data[RTCSL_C2_PIRQ])
			nxt_lvl = 1'b0;
		if (level_event)
			nxt_lvl = 1'b1;
		if (!level_mode)
			nxt_lvl = 1'b0;
		for (int i = 0; i < 2; i++) begin
			nxt_al_dly[i] = al_dly_ff[i];
			nxt_al_run[i] = al_run_ff[i];
			al_hit[i] = 1'b0;
			if (al_run_ff[i]) begin
				if (al_dly_ff[i] <= RTCSL_DLY_W'(1)) begin
					nxt_al_run[i] = 1'b0;
					al_hit[i] = 1'b1;
				end else begin
					nxt_al_dly[i] = al_dly_ff[i] - RTCSL_DLY_W'(1);
				end
			end
			if (i == 0 ? alarm_w_match : alarm_d_match) begin
				nxt_al_run[i] = 1'b1;
				nxt_al_dly[i] = RTCSL_DLY_W'(ALARM_DELAY_CYC);
			end
		end
		nxt_weekly_alarm_flag = weekly_alarm_flag_ff;
		if (wr2 && !reg_wr.data[RTCSL_C2_WEEKLY_ALARM_FLAG])
			nxt_weekly_alarm_flag = 1'b0;
		if (al_hit[0])
			nxt_weekly_alarm_flag = 1'b1;
		if (!ctrl1_ff[RTCSL_C1_WEEKLY_ALARM_ENABLE])
			nxt_weekly_alarm_flag = 1'b0;
		nxt_daily_alarm_flag = daily_alarm_flag_ff;
		if (wr2 && !reg_wr.data[RTCSL_C2_DAILY_ALARM_FLAG])
			nxt_daily_alarm_flag = 1'b0;
		if (al_hit[1])
			nxt_daily_alarm_flag = 1'b1;
		if (!ctrl1_ff[RTCSL_C1_DAILY_ALARM_ENABLE])
			nxt_daily_alarm_flag = 1'b0;
		if (nxt_pon) begin
			nxt_ctrl1 = RTCSL_CTRL1_RST;
			nxt_adj = RTCSL_OSC_ADJ_RST;
			nxt_vsel = 1'b0;
			nxt_vlow = 1'b0;
			nxt_spare_a = 1'b0;
			nxt_lvl = 1'b0;
			nxt_weekly_alarm_flag = 1'b0;
			nxt_daily_alarm_flag = 1'b0;
		end
		nxt_irq_n = ~(per_low | weekly_alarm_flag_ff | daily_alarm_flag_ff);
		nxt_hour = rtcsl_hour_encode(hour_in_bcd, ctrl1_ff[RTCSL_C1_H24]);
		unique case (reg_rd_addr)
			RTCSL_ADDR_CTRL1: nxt_rd = ctrl1_ff;
			RTCSL_ADDR_CTRL2: nxt_rd = {vsel_ff, vlow_ff, xst_ff, pon_ff, spare_a_ff, per_low, weekly_alarm_flag_ff, daily_alarm_flag_ff};
			RTCSL_ADDR_OSC_ADJ: nxt_rd = adj_ff;
			default: nxt_rd = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			osc_prev_ff <= 1'b0;
			ctrl1_ff <= RTCSL_CTRL1_RST;
			adj_ff <= RTCSL_OSC_ADJ_RST;
			pon_ff <= RTCSL_PON_RST;
			xst_ff <= RTCSL_XST_RST;
			vsel_ff <= 1'b0;
			vlow_ff <= 1'b0;
			spare_a_ff <= 1'b0;
			lvl_ff <= 1'b0;
			weekly_alarm_flag_ff <= 1'b0;
			daily_alarm_flag_ff <= 1'b0;
			al_dly_ff[0] <= '0;
			al_dly_ff[1] <= '0;
			al_run_ff <= 2'h0;
			rd_ff <= 8'h00;
			hour_ff <= 6'h00;
			irq_n_ff <= 1'b1;
		end else begin
			osc_prev_ff <= nxt_osc_prev;
			ctrl1_ff <= nxt_ctrl1;
			adj_ff <= nxt_adj;
			pon_ff <= nxt_pon;
			xst_ff <= nxt_xst;
			vsel_ff <= nxt_vsel;
			vlow_ff <= nxt_vlow;
			spare_a_ff <= nxt_spare_a;
			lvl_ff <= nxt_lvl;
			weekly_alarm_flag_ff <= nxt_weekly_alarm_flag;
			daily_alarm_flag_ff <= nxt_daily_alarm_flag;
			al_dly_ff[0] <= nxt_al_dly[0];
			al_dly_ff[1] <= nxt_al_dly[1];
			al_run_ff <= nxt_al_run;
			rd_ff <= nxt_rd;
			hour_ff <= nxt_hour;
			irq_n_ff <= nxt_irq_n;
		end
	end

	assign reg_rd_data = rd_ff;
	assign hour_out = hour_ff;
	assign osc_adj = adj_ff;
	assign hour_24_mode = ctrl1_ff[RTCSL_C1_H24];
	// Test mode is only reachable by software; keeping it at zero is up to the host.
	assign test_mode = ctrl1_ff[RTCSL_C1_TEST];
	assign supply_threshold_select = vsel_ff;
	assign monitor_enable = ~vlow_ff;
	assign irq_out_n = irq_n_ff;

	// ==========================================================================
	// Checks
	// ==========================================================================
	chk_pon_clears_ctrl: assert property (@(posedge sys_clk) disable iff (rst)
		pon_ff |-> (ctrl1_ff == 8'h00 && adj_ff == 8'h00 && !spare_a_ff && !weekly_alarm_flag_ff && !daily_alarm_flag_ff))
		else $error("control bits not zero while power-on flag set");
	chk_pon_write_one: assert property (@(posedge sys_clk) disable iff (rst)
		(pon_ff && !(wr2 && !reg_wr.data[RTCSL_C2_PON])) |=> pon_ff)
		else $error("power-on flag cleared without a zero write");
	chk_fixed_low_out: assert property (@(posedge sys_clk) disable iff (rst)
		(psel == RTCSL_PS_LOW)[*2] |-> !irq_out_n)
		else $error("interrupt not held low for fixed-low select");
	chk_off_high_out: assert property (@(posedge sys_clk) disable iff (rst)
		(psel == RTCSL_PS_OFF && !weekly_alarm_flag_ff && !daily_alarm_flag_ff) |=> irq_out_n)
		else $error("interrupt low with no active source");
	chk_supply_low_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(vlow_ff && !pon_ff && !(wr2 && !reg_wr.data[RTCSL_C2_VLOW])) |=> (vlow_ff && !monitor_enable))
		else $error("supply-low flag dropped without a clear");
	chk_supply_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(vlow_ff && wr2 && !reg_wr.data[RTCSL_C2_VLOW]) |=> (!vlow_ff && monitor_enable))
		else $error("supply-low flag not cleared by zero write");
	chk_halt_forces_zero: assert property (@(posedge sys_clk) disable iff (rst)
		halt_lvl |=> !xst_ff)
		else $error("halt flag not forced low on oscillator halt");
	chk_alarm_off_flag: assert property (@(posedge sys_clk) disable iff (rst)
		!ctrl1_ff[RTCSL_C1_WEEKLY_ALARM_ENABLE] |=> !weekly_alarm_flag_ff)
		else $error("weekly alarm flag set while disabled");
	chk_alarm_delay_set: assert property (@(posedge sys_clk) disable iff (rst)
		(alarm_w_match && ctrl1_ff[RTCSL_C1_WEEKLY_ALARM_ENABLE] && !pon_ff) ##1 (ctrl1_ff[RTCSL_C1_WEEKLY_ALARM_ENABLE] && !wr2)[*2]
		|-> !weekly_alarm_flag_ff || $past(weekly_alarm_flag_ff, 2))
		else $error("weekly alarm flag set too soon after match");
	chk_level_flag_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(level_mode && lvl_ff && !wr1 && !wr2 && !pon_ff) |=> lvl_ff)
		else $error("level flag dropped without a clear");
	chk_twelve_hour_am: assert property (@(posedge sys_clk) disable iff (rst)
		(!ctrl1_ff[RTCSL_C1_H24] && hour_in_bcd == 6'h00) |=> hour_out == 6'h12)
		else $error("midnight not coded as 12 in 12-hour mode");
	chk_twelve_hour_pm: assert property (@(posedge sys_clk) disable iff (rst)
		(!ctrl1_ff[RTCSL_C1_H24] && hour_in_bcd == 6'h13) |=> hour_out == 6'h21)
		else $error("1 PM not coded as 21 in 12-hour mode");
endmodule

// *** core/rtcsl_periodic.sv ***
// Sub-second divider that makes the 2 Hz and 1 Hz waves and the delayed second increment.
`timescale 1ns/100ps
module rtcsl_periodic import rtcsl_pkg::*; #(
	parameter int SEC_DELAY_CYC = RTCSL_SEC_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tick_32k,
	input wire logic sec_write,
	input wire logic adj_due,
	input wire logic adj_slow,
	input wire logic [6:0] adj_ticks,
	output logic wave_1hz_low,
	output logic wave_2hz_low,
	output logic sec_tick
);
	logic [RTCSL_DIV_W-1:0] cnt_ff, nxt_cnt;
	logic [6:0] stall_ff, nxt_stall, amt_ff, nxt_amt;
	logic pend_ff, nxt_pend, slow_ff, nxt_slow;
	logic [RTCSL_DLY_W-1:0] dly_ff, nxt_dly;
	logic run_ff, nxt_run, tick_ff, nxt_tick;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_stall = stall_ff;
		nxt_amt = amt_ff;
		nxt_pend = pend_ff;
		nxt_slow = slow_ff;
		nxt_dly = dly_ff;
		nxt_run = run_ff;
		nxt_tick = 1'b0;
		if (adj_due) begin
			nxt_pend = 1'b1;
			nxt_slow = adj_slow;
			nxt_amt = (adj_ticks > RTCSL_ADJ_MAX_TICKS) ? RTCSL_ADJ_MAX_TICKS : adj_ticks;
		end
		if (run_ff) begin
			if (dly_ff <= RTCSL_DLY_W'(1)) begin
				nxt_run = 1'b0;
				nxt_tick = 1'b1;
			end else begin
				nxt_dly = dly_ff - RTCSL_DLY_W'(1);
			end
		end
		if (sec_write) begin
			nxt_cnt = '0;
			nxt_stall = '0;
			nxt_run = 1'b0;
		end else if (tick_32k) begin
			if (stall_ff != 7'h00) begin
				nxt_stall = stall_ff - 7'h01;
			end else if (&cnt_ff) begin
				nxt_cnt = '0;
				nxt_run = 1'b1;
				nxt_dly = RTCSL_DLY_W'(SEC_DELAY_CYC);
				if (pend_ff) begin
					nxt_pend = 1'b0;
					if (slow_ff)
						nxt_stall = amt_ff;
					else
						nxt_cnt = RTCSL_DIV_W'(amt_ff);
				end
			end else begin
				nxt_cnt = cnt_ff + RTCSL_DIV_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
			stall_ff <= '0;
			amt_ff <= '0;
			pend_ff <= 1'b0;
			slow_ff <= 1'b0;
			dly_ff <= '0;
			run_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			stall_ff <= nxt_stall;
			amt_ff <= nxt_amt;
			pend_ff <= nxt_pend;
			slow_ff <= nxt_slow;
			dly_ff <= nxt_dly;
			run_ff <= nxt_run;
			tick_ff <= nxt_tick;
		end
	end

	// The 1 Hz low half starts at the divider wrap, its falling edge; the 2 Hz wave falls at the wrap and again at mid-count.
	assign wave_1hz_low = ~cnt_ff[RTCSL_DIV_W-1];
	assign wave_2hz_low = ~cnt_ff[RTCSL_DIV_W-2];
	assign sec_tick = tick_ff;
endmodule

// *** core/rtcsl_sync3.sv ***
// Three-stage synchroniser whose output follows once the second and third stages agree.
`timescale 1ns/100ps
module rtcsl_sync3 (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_ff, s2_ff, s3_ff, out_ff;
	logic nxt_out;

	always_comb begin
		nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			out_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign level_out = out_ff;
endmodule

// *** inc/rtcsl_pkg.sv ***
// Package with the register map, field layout, reset values, timing counts and helpers of the control block.
package rtcsl_pkg;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [3:0] RTCSL_ADDR_SEC = 4'h0;
	localparam logic [3:0] RTCSL_ADDR_OSC_ADJ = 4'h7;
	localparam logic [3:0] RTCSL_ADDR_CTRL1 = 4'hE;
	localparam logic [3:0] RTCSL_ADDR_CTRL2 = 4'hF;

	// Fields of alarm_mode_irq_ctrl.
	localparam int RTCSL_C1_WEEKLY_ALARM_ENABLE = 7;
	localparam int RTCSL_C1_DAILY_ALARM_ENABLE = 6;
	localparam int RTCSL_C1_H24 = 5;
	localparam int RTCSL_C1_SPARE_B = 4;
	localparam int RTCSL_C1_TEST = 3;
	localparam int RTCSL_C1_SEL_LSB = 0;

	// Fields of supply_osc_status_ctrl.
	localparam int RTCSL_C2_VSEL = 7;
	localparam int RTCSL_C2_VLOW = 6;
	localparam int RTCSL_C2_XST = 5;
	localparam int RTCSL_C2_PON = 4;
	localparam int RTCSL_C2_SPARE_A = 3;
	localparam int RTCSL_C2_PIRQ = 2;
	localparam int RTCSL_C2_WEEKLY_ALARM_FLAG = 1;
	localparam int RTCSL_C2_DAILY_ALARM_FLAG = 0;

	localparam logic [7:0] RTCSL_CTRL1_RST = 8'h00;
	localparam logic [7:0] RTCSL_OSC_ADJ_RST = 8'h00;
	localparam logic RTCSL_PON_RST = 1'h1;
	localparam logic RTCSL_XST_RST = 1'h0;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int RTCSL_CLK_PERIOD_NS = 10;
	localparam int RTCSL_SEC_DELAY_NS = 92000;
	localparam int RTCSL_SEC_DELAY_CYC = RTCSL_SEC_DELAY_NS / RTCSL_CLK_PERIOD_NS;
	localparam int RTCSL_ALARM_DELAY_NS = 61000;
	localparam int RTCSL_ALARM_DELAY_CYC = RTCSL_ALARM_DELAY_NS / RTCSL_CLK_PERIOD_NS;
	localparam int RTCSL_DLY_W = 16;
	localparam int RTCSL_DIV_W = 15;
	localparam longint RTCSL_OSC_HZ = 32768;
	localparam longint RTCSL_ADJ_MAX_NS = 3784000;
	localparam logic [6:0] RTCSL_ADJ_MAX_TICKS = 7'((RTCSL_ADJ_MAX_NS * RTCSL_OSC_HZ) / 64'd1000000000);

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [2:0] {
		RTCSL_PS_OFF = 3'b000,
		RTCSL_PS_LOW = 3'b001,
		RTCSL_PS_P2HZ = 3'b010,
		RTCSL_PS_P1HZ = 3'b011,
		RTCSL_PS_LSEC = 3'b100,
		RTCSL_PS_LMIN = 3'b101,
		RTCSL_PS_LHOUR = 3'b110,
		RTCSL_PS_LMONTH = 3'b111
	} rtcsl_psel_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} rtcsl_reg_wr_t;

	// Carries that the time counters report together with the second increment.
	typedef struct packed {
		logic month;
		logic hour;
		logic minute;
	} rtcsl_carry_t;

	// ==========================================================================
	// Helpers
	// ==========================================================================
	function automatic logic [4:0] rtcsl_bcd2bin(input logic [5:0] bcd);
		// Widen the digits first so that tens of 20 do not wrap in a four-bit product.
		rtcsl_bcd2bin = 5'(bcd[5:4]) * 5'd10 + 5'(bcd[3:0]);
	endfunction

	function automatic logic [5:0] rtcsl_bin2bcd(input logic [4:0] bin);
		logic [4:0] tens;
		tens = (bin >= 5'd20) ? 5'd2 : (bin >= 5'd10) ? 5'd1 : 5'd0;
		rtcsl_bin2bcd = {tens[1:0], 4'(bin - 5'(tens * 5'd10))};
	endfunction

	// Maps a 24-hour BCD hour onto the register coding of the selected mode.
	function automatic logic [5:0] rtcsl_hour_encode(input logic [5:0] h24, input logic mode24);
		logic [4:0] b;
		b = rtcsl_bcd2bin(h24);
		if (mode24)
			rtcsl_hour_encode = h24;
		else if (b == 5'd0)
			rtcsl_hour_encode = 6'h12;
		else if (b < 5'd12)
			rtcsl_hour_encode = h24;
		else if (b == 5'd12)
			rtcsl_hour_encode = 6'h32;
		else
			rtcsl_hour_encode = rtcsl_bin2bcd(5'(b - 5'd12)) | 6'h20;
	endfunction

endpackage
